// >>> common/swsl_pkg.sv
// constants and types for the single-wire slave link with search support
// Summary of operation
// - search command F0h resolves 64-bit codes by elimination
// - per bit: send bit, complement, take master bit
// - master starts all slots; device makes presence only
// - after reset release wait delay, then drive presence
// - data accepted only after presence pulse and hold-off; code also takes slots straight after rstn
// - each slot carries exactly one bit
// - falling edge starts device slot timer
// - recovery interval needed between slots
// - zero sent by holding low until timer ends
// - active below low threshold, idle above high
// - slot-start falling edge is low-pass filtered
// - shallow glitch within hysteresis is ignored
// - glitches inside hold-off ignored, later start slot
// - low over 120 us means bus reset
package swsl_pkg;
  localparam int unsigned CLK_HZ            = 25_000_000;
  // times in nanoseconds
  localparam int unsigned T_RESET_DET_NS     = 120_000;
  localparam int unsigned T_PRES_HIGH_NS     = 30_000;
  localparam int unsigned T_PRES_LOW_NS      = 120_000;
  localparam int unsigned T_WRITE_SAMPLE_NS  = 30_000;
  localparam int unsigned T_READ_HOLD_NS     = 30_000;
  localparam int unsigned T_HOLDOFF_NS       = 1_000;
  localparam int unsigned T_FILTER_NS        = 200;
  // least times round up
  localparam int unsigned C_RESET_DET =
    (T_RESET_DET_NS * 25 + 999) / 1000;
  localparam int unsigned C_PRES_HIGH = (T_PRES_HIGH_NS * 25 + 999) / 1000;
  localparam int unsigned C_PRES_LOW  = (T_PRES_LOW_NS * 25 + 999) / 1000;
  localparam int unsigned C_WR_SAMPLE = (T_WRITE_SAMPLE_NS * 25 + 999) / 1000;
  localparam int unsigned C_RD_HOLD   = (T_READ_HOLD_NS * 25 + 999) / 1000;
  localparam int unsigned C_HOLDOFF   = (T_HOLDOFF_NS * 25 + 999) / 1000;
  localparam int unsigned C_FILTER    = (T_FILTER_NS * 25 + 999) / 1000;
  localparam int unsigned CNT_W       = 13;
  localparam logic [7:0]  CMD_SEARCH  = 8'hF0;
  localparam int unsigned CODE_BITS   = 64;
  localparam int unsigned FILT_W      = 4;
  // arbitrary identity code; real part value deliberately not used
  localparam logic [63:0] ID_DEFAULT  = 64'h0123_4567_89AB_CD5A;

  typedef enum logic [5:0] {
    SW_IDLE   = 6'b000001,
    SW_PHIGH  = 6'b000010,
    SW_PLOW   = 6'b000100,
    SW_SLOT   = 6'b001000,
    SW_WAITHI = 6'b010000,
    SW_HOLD   = 6'b100000
  } swsl_state_t;

  typedef enum logic [3:0] {
    SP_CMD    = 4'b0001,
    SP_BIT    = 4'b0010,
    SP_CMP    = 4'b0100,
    SP_TAKE   = 4'b1000
  } swsl_phase_t;
endpackage

// >>> common/swsl_line_if.sv
// line front end signals between filter and link core
`timescale 1ns/1ps
interface swsl_line_if;
  logic lineLow;
  logic fallEvt;
  logic riseEvt;
  modport filt (output lineLow, output fallEvt, output riseEvt);
  modport core (input lineLow, input fallEvt, input riseEvt);
endinterface

// >>> rtl/swsl_filter.sv
// glitch filter for the data line
`timescale 1ns/1ps
module swsl_filter (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // raw comparators and hold-off gate
  input  wire logic belowLow,
  input  wire logic aboveHigh,
  input  wire logic holdOff,
  // filtered line
  swsl_line_if.filt line
);
  import swsl_pkg::*;

  logic [FILT_W-1:0] lowCnt;
  logic              state;

  // --------------------------------------------------------------
  // debounce
  // --------------------------------------------------------------
  // low requires sustained below-low-threshold; hysteresis band keeps state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lowCnt <= '0;
    end else if (!belowLow || holdOff || state) begin
      lowCnt <= '0;
    end else if (lowCnt != FILT_W'(C_FILTER)) begin
      lowCnt <= lowCnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state        <= 1'b0;
      line.fallEvt <= 1'b0;
      line.riseEvt <= 1'b0;
    end else begin
      line.fallEvt <= 1'b0;
      line.riseEvt <= 1'b0;
      if (!state && lowCnt == FILT_W'(C_FILTER)) begin
        state        <= 1'b1;
        line.fallEvt <= 1'b1;
      end else if (state && aboveHigh) begin
        state        <= 1'b0;
        line.riseEvt <= 1'b1;
      end
    end
  end
  assign line.lineLow = state;

  a_fall_filtered: assert property (@(posedge clk_sys) disable iff (!rstn)
    line.fallEvt |-> $past(belowLow, 2) && $past(belowLow, 6)
                     && !$past(holdOff, 2))
    else $error("fall accepted without filtered low");
endmodule

// >>> rtl/swsl_link.sv
// single-wire slave link bit layer with search participation
`timescale 1ns/1ps
module swsl_link (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // line comparators
  input  wire logic        belowLow,
  input  wire logic        aboveHigh,
  // open drain pull-down
  output logic             dqOut,
  output logic             dqOe,
  // identity and status
  input  wire logic [63:0] idCode,
  output logic             presenceDone,
  output logic             searchActive,
  output logic             dropped
);
  import swsl_pkg::*;

  swsl_line_if line ();
  swsl_state_t st;
  swsl_phase_t ph;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] lowCnt;
  logic [7:0]       cmdSh;
  logic [2:0]       cmdBits;
  logic [5:0]       bitIdx;
  logic             sendBit;
  logic             holdOff;
  logic             busReset;
  logic             curBit;
  logic             resetSeen;

  swsl_filter u_filt (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .belowLow  (belowLow),
    .aboveHigh (aboveHigh),
    .holdOff   (holdOff),
    .line      (line)
  );

  assign curBit  = idCode[bitIdx];
  assign holdOff = (st == SW_HOLD);
  assign busReset = line.lineLow && lowCnt >= CNT_W'(C_RESET_DET);

  // --------------------------------------------------------------
  // bus reset detect
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lowCnt <= '0;
    end else if (!line.lineLow) begin
      lowCnt <= '0;
    end else if (lowCnt != CNT_W'(C_RESET_DET)) begin
      lowCnt <= lowCnt + 1'b1;
    end
  end

  // --------------------------------------------------------------
  // slot sequencer
  // --------------------------------------------------------------
  // presence drive is filtered back in; its fall event is ignored outside SW_IDLE
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st  <= SW_IDLE;
      cnt <= '0;
    end else begin
      unique case (st)
        SW_IDLE: begin
          cnt <= '0;
          if (line.fallEvt) begin
            st <= SW_SLOT;
          end
        end
        SW_SLOT: begin
          cnt <= cnt + 1'b1;
          if (busReset) begin
            st <= SW_WAITHI;
          end else if (cnt == CNT_W'(C_RD_HOLD)) begin
            st <= SW_WAITHI;
          end
        end
        SW_WAITHI: begin
          cnt <= '0;
          // a short low slot rises long before the slot timer ends
          if (line.riseEvt || !line.lineLow) begin
            st <= resetSeen ? SW_PHIGH : SW_HOLD;
          end
        end
        SW_HOLD: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(C_HOLDOFF)) begin
            st  <= SW_IDLE;
            cnt <= '0;
          end
        end
        SW_PHIGH: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(C_PRES_HIGH)) begin
            st  <= SW_PLOW;
            cnt <= '0;
          end
        end
        SW_PLOW: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(C_PRES_LOW)) begin
            st  <= SW_HOLD;
            cnt <= '0;
          end
        end
        default: st <= SW_IDLE;
      endcase
    end
  end

  // reset-latched flag held until presence; the low counter is gone by the
  // time the rise is seen, so the sequencer decides on this flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resetSeen <= 1'b0;
    end else if (busReset) begin
      resetSeen <= 1'b1;
    end else if (st == SW_PLOW) begin
      resetSeen <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // bit protocol: command byte then search triplets
  // --------------------------------------------------------------
  logic sampleNow;
  assign sampleNow = (st == SW_SLOT) && cnt == CNT_W'(C_WR_SAMPLE)
                     && !busReset;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph      <= SP_CMD;
      cmdSh   <= '0;
      cmdBits <= '0;
      bitIdx  <= '0;
      dropped <= 1'b0;
    end else if (st == SW_PLOW) begin
      ph      <= SP_CMD;
      cmdBits <= '0;
      bitIdx  <= '0;
      dropped <= 1'b0;
    end else if (sampleNow && !dropped) begin
      unique case (ph)
        SP_CMD: begin
          // one bit per slot, lsb first
          cmdSh   <= {line.lineLow ? 1'b0 : 1'b1, cmdSh[7:1]};
          cmdBits <= cmdBits + 1'b1;
          if (cmdBits == 3'd7) begin
            if ({line.lineLow ? 1'b0 : 1'b1, cmdSh[7:1]} == CMD_SEARCH) begin
              ph <= SP_BIT;
            end else begin
              dropped <= 1'b1; // other commands not handled here
            end
          end
        end
        SP_BIT:  ph <= SP_CMP;
        SP_CMP:  ph <= SP_TAKE;
        SP_TAKE: begin
          if ((line.lineLow ? 1'b0 : 1'b1) != curBit) begin
            dropped <= 1'b1;
          end else if (bitIdx == 6'(CODE_BITS - 1)) begin
            dropped <= 1'b1; // pass complete; wait for reset
          end
          bitIdx <= bitIdx + 1'b1;
          ph     <= SP_BIT;
        end
        default: ph <= SP_CMD;
      endcase
    end
  end

  // sent bit fixed at the slot start
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sendBit <= 1'b1;
    end else if (line.fallEvt) begin
      sendBit <= dropped ? 1'b1 :
                 (ph == SP_BIT) ? curBit :
                 (ph == SP_CMP) ? !curBit : 1'b1;
    end
  end

  // --------------------------------------------------------------
  // pin and status outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dqOe         <= 1'b0;
      dqOut        <= 1'b0;
      presenceDone <= 1'b0;
      searchActive <= 1'b0;
    end else begin
      dqOut        <= 1'b0;
      // zero held only inside the device read window
      dqOe         <= (st == SW_PLOW && cnt != CNT_W'(C_PRES_LOW)) ||
                      (st == SW_SLOT && !sendBit && !busReset &&
                       cnt != CNT_W'(C_RD_HOLD));
      presenceDone <= (st == SW_PLOW) ? 1'b1 :
                      (busReset ? 1'b0 : presenceDone);
      searchActive <= ph != SP_CMD && !dropped;
    end
  end

  a_pres_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(st == SW_PLOW) |-> $past(st == SW_PHIGH))
    else $error("presence without high delay");
  a_pres_width: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(st == SW_PLOW) |=> dqOe [*8])
    else $error("presence pulse too short");
  a_slot_start: assert property (@(posedge clk_sys) disable iff (!rstn)
    st == SW_IDLE && line.fallEvt |=> st == SW_SLOT)
    else $error("slot timer not started");
  a_drop_silent: assert property (@(posedge clk_sys) disable iff (!rstn)
    dropped && st == SW_SLOT && !busReset |=> !dqOe)
    else $error("dropped device drives line");
  a_one_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    st == SW_SLOT && sendBit |=> !dqOe)
    else $error("one bit drove line");
  a_reset_detect: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(line.lineLow) && $past(busReset) |=> st == SW_PHIGH)
    else $error("long low not a reset");
  a_hold_ignore: assert property (@(posedge clk_sys) disable iff (!rstn)
    st == SW_HOLD |-> !line.fallEvt)
    else $error("edge during hold-off");
  a_cmp_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
    line.fallEvt && ph == SP_CMP && !dropped |=> sendBit == !curBit)
    else $error("complement wrong");

  c_presence: cover property (@(posedge clk_sys) $rose(presenceDone));
  c_search:   cover property (@(posedge clk_sys) $rose(searchActive));
  c_drop:     cover property (@(posedge clk_sys)
    searchActive ##1 dropped);
endmodule

// >>> tb/swsl_master.sv
// bus master model driving the single data line of the slave link
`timescale 1ns/1ps
module swsl_master (
  // clock
  input  wire logic clk_sys,
  // device pull-down
  input  wire logic dqOe,
  // line comparators seen by the device, line level for the bench
  output logic      belowLow,
  output logic      aboveHigh,
  output logic      lineHigh
);
  logic pullLow;
  logic shallow;

  // ------------------------------------------------------------
  // wired line: pull-up, either party may pull low
  // ------------------------------------------------------------
  assign lineHigh  = !(pullLow | dqOe);
  assign belowLow  = !lineHigh;
  // shallow dip leaves high comparator only
  assign aboveHigh = lineHigh & !shallow;

  initial begin
    pullLow = 1'b0;
    shallow = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // signalling, every kind started by the master
  // ------------------------------------------------------------
  task automatic reset_pulse();
    pullLow = 1'b1;
    hold(12000);
    pullLow = 1'b0;
  endtask

  // hg: deep glitch just after the rise, inside the hold-off only for a zero bit
  task automatic write_bit(input logic b, input logic hg);
    pullLow = 1'b1;
    hold(b ? 50 : 1500);
    pullLow = 1'b0;
    hold(5);
    pullLow = hg;
    hold(10);
    pullLow = 1'b0;
    hold(b ? 1560 : 110);
  endtask

  task automatic read_bit(output logic b);
    pullLow = 1'b1;
    hold(50);
    pullLow = 1'b0;
    hold(275);
    b = lineHigh;
    hold(1300);
  endtask

  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      write_bit(v[i], 1'b0);
    end
  endtask

  task automatic glitch(input logic deep, input int n);
    pullLow = deep;
    shallow = !deep;
    hold(n);
    pullLow = 1'b0;
    shallow = 1'b0;
    hold(200);
  endtask
endmodule

// >>> tb/swsl_link_bench.sv
// self-checking bench for the slave link bit layer and search
`timescale 1ns/1ps
module swsl_link_bench;
  import swsl_pkg::*;
  // arbitrary code, low bits 0,0,0,1,1
  localparam logic [63:0] TEST_ID = 64'h5A3C_96E1_0F2D_B478;

  logic clk_sys;
  logic rstn;
  logic belowLow;
  logic aboveHigh;
  logic lineHigh;
  logic dqOut;
  logic dqOe;
  logic presenceDone;
  logic searchActive;
  logic dropped;
  int   badCount;
  int   checksDone;

  swsl_master i_swsl_master (
    .clk_sys   (clk_sys),
    .dqOe      (dqOe),
    .belowLow  (belowLow),
    .aboveHigh (aboveHigh),
    .lineHigh  (lineHigh)
  );

  swsl_link i_swsl_link (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .belowLow     (belowLow),
    .aboveHigh    (aboveHigh),
    .dqOut        (dqOut),
    .dqOe         (dqOe),
    .idCode       (TEST_ID),
    .presenceDone (presenceDone),
    .searchActive (searchActive),
    .dropped      (dropped)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      badCount++;
    end
  endtask

  task automatic finishTest();
    $display("mismatches %0d of %0d checks", badCount, checksDone);
    if (badCount == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_presence();
    int   d;
    int   l;
    logic atSample;
    atSample = 1'b1;
    i_swsl_master.reset_pulse();
    check("presence cleared", 32'(presenceDone), 32'h0);
    d = 0;
    while (!dqOe && d < 2000) begin
      @(negedge clk_sys);
      d++;
    end
    check("presence delay", 32'(d >= C_PRES_HIGH && d <= C_PRES_HIGH + 8),
          32'h1);
    l = 0;
    while (dqOe && l < 4000) begin
      @(negedge clk_sys);
      l++;
      if (d + l == 1750) begin
        atSample = lineHigh;
      end
    end
    check("presence length", 32'(l >= C_PRES_LOW && l <= C_PRES_LOW + 8),
          32'h1);
    check("line at sample", 32'(atSample), 32'h0);
    check("presence flag", 32'(presenceDone), 32'h1);
    check("dropped cleared", 32'(dropped), 32'h0);
    if (d >= 2000 || l >= 4000) begin
      finishTest();
    end
    // slack for slowest legal presence timing
    repeat (7625 - d - l) @(negedge clk_sys);
  endtask

  // search bits with glitches between slots, then mismatch
  task automatic t_search_drop();
    logic a;
    logic b;
    i_swsl_master.write_byte(CMD_SEARCH);
    check("search active", 32'(searchActive), 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (i == 1) i_swsl_master.glitch(1'b0, 30);
      if (i == 2) i_swsl_master.glitch(1'b1, 3);
      i_swsl_master.read_bit(a);
      i_swsl_master.read_bit(b);
      check("code bit", 32'(a), 32'(TEST_ID[i]));
      check("complement", 32'(b), 32'(!TEST_ID[i]));
      // last bit written opposite to drop the device
      i_swsl_master.write_bit(TEST_ID[i] ^ (i == 4), i == 2);
    end
    check("dropped", 32'(dropped), 32'h1);
    check("search ended", 32'(searchActive), 32'h0);
    i_swsl_master.read_bit(a);
    check("silent bit", 32'(a), 32'h1);
  endtask

  // five triplets taken; a glitch seen as a slot shifts the count
  task automatic t_glitch_sync();
    check("bits", 32'(i_swsl_link.bitIdx), 32'h5);
  endtask

  task automatic t_other_cmd();
    logic a;
    t_presence();
    i_swsl_master.write_byte(8'hCC);
    check("other cmd drops", 32'(dropped), 32'h1);
    check("other cmd idle", 32'(searchActive), 32'h0);
    i_swsl_master.read_bit(a);
    check("other cmd silent", 32'(a), 32'h1);
  endtask

  initial begin
    badCount   = 0;
    checksDone = 0;
    rstn       = 1'b0;
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("idle drive", 32'(dqOe), 32'h0);
    check("pin level", 32'(dqOut), 32'h0);
    t_presence();
    t_search_drop();
    t_glitch_sync();
    t_other_cmd();
    finishTest();
  end
endmodule
